// >>> logic/pmas_pkg.sv
// constants for the power monitor converter sequencer
// assumes a 200 MHz core clock and a register write strobe from the bus side
package pmas_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int unsigned CAL_BIT = 7;
	localparam int unsigned MODE_HI = 6;
	localparam int unsigned MODE_LO = 5;
	localparam int unsigned CSEL_HI = 4;
	localparam int unsigned CSEL_LO = 3;
	localparam int unsigned SSEL_HI = 2;
	localparam int unsigned SSEL_LO = 0;
	localparam logic [1:0] MODE_CONT = 2'h0;
	localparam logic [1:0] MODE_SNAP = 2'h1;
	localparam logic [1:0] MODE_SINGLE = 2'h2;
	localparam logic [1:0] MODE_SHDN = 2'h3;
	localparam logic [1:0] CSEL_ALL = 2'h0;
	localparam logic [1:0] CSEL_SUP = 2'h1;
	localparam logic [1:0] CSEL_G12 = 2'h2;
	localparam logic [1:0] CSEL_G4 = 2'h3;
	localparam logic [2:0] SSEL_SUP = 3'h6;
	localparam logic [2:0] SSEL_G12 = 3'h7;
	// input indices: 0 supply1, 1 supply2, 2..5 gpio1..4
	localparam logic [2:0] IN_S1 = 3'h0;
	localparam logic [2:0] IN_S2 = 3'h1;
	localparam logic [2:0] IN_G1 = 3'h2;
	localparam logic [2:0] IN_G2 = 3'h3;
	localparam logic [2:0] IN_G3 = 3'h4;
	localparam logic [2:0] IN_G4 = 3'h5;
	// default conversion time in microseconds (scaled in simulation)
	localparam int unsigned VCONV_US = 16400;
	localparam int unsigned VCONV_CYC = VCONV_US * CLK_MHZ;
	localparam int unsigned ICONV_US = 32800;
	localparam int unsigned ICONV_CYC = ICONV_US * CLK_MHZ;
	localparam int unsigned CAL_US = 16400;
	localparam int unsigned CAL_CYC = CAL_US * CLK_MHZ;
endpackage : pmas_pkg

// >>> logic/pmas_sequencer.sv
// converter sequencing for a dual supply power monitor
// assumes ctrl_wr is a one-cycle pulse from the serial-bus slave and
// bus_busy is a synchronous level from that slave, same clock
`timescale 1ns/10ps
`default_nettype none

module pmas_sequencer #(
	parameter int unsigned VCONV_CYCLES = pmas_pkg::VCONV_CYC,
	parameter int unsigned ICONV_CYCLES = pmas_pkg::ICONV_CYC,
	parameter int unsigned CAL_CYCLES = pmas_pkg::CAL_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic bus_busy,
	input wire logic [1:0] alert_enable_group4,
	output logic [7:0] adc_sequence_control,
	output logic converters_on,
	output logic [2:0] vconv_input,
	output logic vconv_update,
	output logic [2:0] vconv_upd_input,
	output logic [1:0] iconv_update,
	output logic cal_active,
	output logic [1:0] power_update,
	output logic power_use_gpio,
	output logic [1:0] status_new,
	output logic snap_alert
);
	typedef enum logic [1:0] {
		PMAS_IDLE = 2'b00,
		PMAS_CAL = 2'b01,
		PMAS_RUN = 2'b10
	} pmas_state_t;

	pmas_state_t state_r;
	logic [31:0] vcnt_r;
	logic [31:0] icnt_r;
	logic [2:0] vidx_r;
	logic vdone_r;
	logic idone_r;
	logic seq_fresh_r;
	logic [1:0] mode;
	logic [1:0] csel;
	logic [2:0] ssel;
	logic vtick;
	logic itick;
	logic snap_pair;
	logic [2:0] vfirst;
	logic [2:0] vlast;
	logic [2:0] vnext;
	logic commit;

	assign mode = adc_sequence_control[pmas_pkg::MODE_HI:pmas_pkg::MODE_LO];
	assign csel = adc_sequence_control[pmas_pkg::CSEL_HI:pmas_pkg::CSEL_LO];
	assign ssel = adc_sequence_control[pmas_pkg::SSEL_HI:pmas_pkg::SSEL_LO];
	assign snap_pair = (ssel == pmas_pkg::SSEL_SUP) ||
		(ssel == pmas_pkg::SSEL_G12);
	assign vtick = (state_r == PMAS_RUN) && !vdone_r &&
		(vcnt_r == VCONV_CYCLES - 1);
	assign itick = (state_r == PMAS_RUN) && !idone_r &&
		(icnt_r == ICONV_CYCLES - 1);
	// results land only while the bus is quiet; otherwise dropped
	assign commit = !bus_busy;

	// input range of the voltage scan
	always_comb begin
		vfirst = pmas_pkg::IN_S1;
		vlast = pmas_pkg::IN_G4;
		if (mode == pmas_pkg::MODE_SNAP) begin
			if (ssel == pmas_pkg::SSEL_G12) begin
				vfirst = pmas_pkg::IN_G1;
				vlast = pmas_pkg::IN_G2;
			end else if (ssel == pmas_pkg::SSEL_SUP) begin
				vfirst = pmas_pkg::IN_S1;
				vlast = pmas_pkg::IN_S2;
			end else begin
				vfirst = ssel;
				vlast = ssel;
			end
		end else if (mode == pmas_pkg::MODE_CONT) begin
			case (csel)
				pmas_pkg::CSEL_G4: begin
					vfirst = pmas_pkg::IN_G1;
					vlast = pmas_pkg::IN_G4;
				end
				pmas_pkg::CSEL_G12: begin
					vfirst = pmas_pkg::IN_G1;
					vlast = pmas_pkg::IN_G2;
				end
				pmas_pkg::CSEL_SUP: begin
					vfirst = pmas_pkg::IN_S1;
					vlast = pmas_pkg::IN_S2;
				end
				default: begin
					vfirst = pmas_pkg::IN_S1;
					vlast = pmas_pkg::IN_G4;
				end
			endcase
		end
		vnext = (vidx_r == vlast) ? vfirst : vidx_r + 3'h1;
	end

	// control register, reset default is continuous with calibration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_sequence_control <= pmas_pkg::CTRL_RESET;
		end else if (ctrl_wr) begin
			adc_sequence_control <= ctrl_wdata;
		end
	end

	// sequence state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= PMAS_CAL;
			seq_fresh_r <= 1'b0;
		end else if (ctrl_wr) begin
			// restart on every write except shutdown, which goes idle
			state_r <= (ctrl_wdata[pmas_pkg::MODE_HI:pmas_pkg::MODE_LO] ==
				pmas_pkg::MODE_SHDN) ? PMAS_IDLE : PMAS_CAL;
			seq_fresh_r <= 1'b1;
		end else begin
			case (state_r)
				PMAS_IDLE: state_r <= PMAS_IDLE;
				PMAS_CAL: begin
					if (icnt_r == CAL_CYCLES - 1) begin
						state_r <= PMAS_RUN;
						seq_fresh_r <= 1'b0;
					end
				end
				PMAS_RUN: begin
					if (mode != pmas_pkg::MODE_CONT && vdone_r && idone_r) begin
						state_r <= PMAS_IDLE;
					end else if (mode == pmas_pkg::MODE_CONT && itick &&
						!adc_sequence_control[pmas_pkg::CAL_BIT]) begin
						state_r <= PMAS_CAL;
					end
				end
				default: state_r <= PMAS_IDLE;
			endcase
		end
	end

	// conversion counters and scan pointer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vcnt_r <= 32'h0;
			icnt_r <= 32'h0;
			vidx_r <= pmas_pkg::IN_S1;
			vdone_r <= 1'b0;
			idone_r <= 1'b0;
		end else if (ctrl_wr || state_r == PMAS_IDLE) begin
			vcnt_r <= 32'h0;
			icnt_r <= 32'h0;
			vidx_r <= vfirst;
			vdone_r <= 1'b0;
			idone_r <= 1'b0;
		end else if (state_r == PMAS_CAL) begin
			// calibration uses the current timer; voltage scan pauses for
			// every calibration, a simplification of the parallel timing
			icnt_r <= (icnt_r == CAL_CYCLES - 1) ? 32'h0 : icnt_r + 32'h1;
			// the write edge still decodes the old range, so reload here
			if (seq_fresh_r) begin
				vidx_r <= vfirst;
			end
			if (!vdone_r && vcnt_r != 32'h0) begin
				vcnt_r <= vcnt_r;
			end
		end else begin
			if (!vdone_r) begin
				vcnt_r <= vtick ? 32'h0 : vcnt_r + 32'h1;
			end
			if (vtick) begin
				vidx_r <= vnext;
				if (mode != pmas_pkg::MODE_CONT && vidx_r == vlast) begin
					vdone_r <= 1'b1;
				end
			end
			if (!idone_r) begin
				icnt_r <= itick ? 32'h0 : icnt_r + 32'h1;
			end
			if (itick && mode != pmas_pkg::MODE_CONT) begin
				idone_r <= 1'b1;
			end
		end
	end

	// result update strobes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vconv_update <= 1'b0;
			vconv_upd_input <= pmas_pkg::IN_S1;
			iconv_update <= 2'h0;
			power_update <= 2'h0;
			power_use_gpio <= 1'b0;
		end else begin
			vconv_update <= vtick && commit;
			vconv_upd_input <= vidx_r;
			iconv_update <= {2{itick && commit}};
			// power only where two voltage operands exist, supply or gpio
			power_update <= {2{itick && commit &&
				(mode != pmas_pkg::MODE_SNAP || snap_pair)}};
			if (mode == pmas_pkg::MODE_SNAP) begin
				power_use_gpio <= (ssel == pmas_pkg::SSEL_G12);
			end else if (mode == pmas_pkg::MODE_CONT) begin
				power_use_gpio <= csel[1];
			end else begin
				power_use_gpio <= 1'b0;
			end
		end
	end

	// snapshot completion status and alert
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_new <= 2'h0;
			snap_alert <= 1'b0;
		end else begin
			status_new <= 2'h0;
			snap_alert <= 1'b0;
			if (state_r == PMAS_RUN && mode == pmas_pkg::MODE_SNAP &&
				vdone_r && idone_r) begin
				status_new <= 2'h3;
				snap_alert <= |alert_enable_group4;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			converters_on <= 1'b0;
			cal_active <= 1'b0;
			vconv_input <= pmas_pkg::IN_S1;
		end else begin
			converters_on <= (state_r != PMAS_IDLE);
			cal_active <= (state_r == PMAS_CAL);
			vconv_input <= vidx_r;
		end
	end

	AST_SHDN_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl_wr && ctrl_wdata[6:5] == 2'h3) |=> ##1 !converters_on)
		else $error("shutdown left converters on");
	AST_WR_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl_wr && ctrl_wdata[6:5] != 2'h3) |=> state_r == PMAS_CAL)
		else $error("write did not restart sequence");
	AST_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
		$past(bus_busy) |-> !vconv_update && iconv_update == 2'h0)
		else $error("update during bus activity");
	AST_DISCARD: assert property (@(posedge clk) disable iff (!rst_n)
		(vtick && bus_busy) |=> !vconv_update)
		else $error("blocked result not discarded");
	AST_SNAP_NOPWR: assert property (@(posedge clk) disable iff (!rst_n)
		(itick && mode == 2'h1 && ssel <= 3'h5) |=> power_update == 2'h0)
		else $error("single snapshot updated power");
	AST_SNAP_HALT: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == PMAS_RUN && mode == 2'h1 && vdone_r && idone_r &&
		!ctrl_wr) |=> state_r == PMAS_IDLE ##1 !converters_on)
		else $error("snapshot did not halt");
	AST_SNAP_STAT: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == PMAS_RUN && mode == 2'h1 && vdone_r && idone_r) |=>
		status_new == 2'h3 && snap_alert == $past(|alert_enable_group4))
		else $error("snapshot status missing");
	AST_CAL_EVERY: assert property (@(posedge clk) disable iff (!rst_n)
		(itick && mode == 2'h0 && !adc_sequence_control[7] && !ctrl_wr)
		|=> state_r == PMAS_CAL)
		else $error("no calibration per conversion");
	AST_SCAN: assert property (@(posedge clk) disable iff (!rst_n)
		(vtick && mode == 2'h0 && !ctrl_wr) |=> vidx_r == $past(vnext))
		else $error("scan order broken");
	AST_PWR_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
		$past(bus_busy) |-> power_update == 2'h0)
		else $error("power update during bus activity");
	AST_SNAP_IN: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == PMAS_RUN && mode == 2'h1 && ssel <= 3'h5) |->
		vidx_r == ssel)
		else $error("snapshot converts wrong input");
endmodule : pmas_sequencer

`default_nettype wire

// >>> tb/pmas_host_model.sv
// host side model: control register writes and bus activity level
// assumes the bench calls its tasks; all changes land at falling edges
`timescale 1ns/10ps
`default_nettype none
module pmas_host_model (
	input wire logic clk,
	output logic ctrl_wr,
	output logic [7:0] ctrl_wdata,
	output logic bus_busy
);
	initial begin
		ctrl_wr = 1'b0;
		ctrl_wdata = 8'h00;
		bus_busy = 1'b0;
	end
	// a finished snapshot needs a fresh write to repeat
	task automatic write_ctrl(input logic [7:0] d);
		@(negedge clk);
		ctrl_wr = 1'b1;
		ctrl_wdata = d;
		@(negedge clk);
		ctrl_wr = 1'b0;
		// released data does not keep the last value
		ctrl_wdata = ~d;
	endtask : write_ctrl
	// no traffic by default; busy only while a test holds it
	task automatic set_busy(input logic b);
		@(negedge clk);
		bus_busy = b;
	endtask : set_busy
endmodule : pmas_host_model
`default_nettype wire

// >>> tb/test_power_monitor_adc_sequencer.sv
// bench for the converter sequencer: writes, pulse counts, halts
// assumes counts shortened to 20/40/10 cycles
`timescale 1ns/10ps
`default_nettype none
module test_power_monitor_adc_sequencer;
	logic clk, rst_n, ctrl_wr, bus_busy, converters_on, vconv_update;
	logic cal_active, power_use_gpio, snap_alert, cal_d;
	logic [7:0] ctrl_wdata, adc_sequence_control, vmask, d, imask, emask;
	logic [1:0] al_en, iconv_update, power_update, status_new;
	logic [2:0] vconv_input, vconv_upd_input;
	int error_cnt, cmp_count, nv, ni, np, ns, na, nc, ng, k, s;
	logic [7:0] cmask [4] = '{8'h3f, 8'h03, 8'h0c, 8'h3c};
	pmas_host_model pmas_host_model_i (.clk(clk), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .bus_busy(bus_busy));
	pmas_sequencer #(.VCONV_CYCLES(20), .ICONV_CYCLES(40), .CAL_CYCLES(10))
	pmas_sequencer_i (.clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .bus_busy(bus_busy),
		.alert_enable_group4(al_en), .adc_sequence_control(adc_sequence_control),
		.converters_on(converters_on), .vconv_input(vconv_input),
		.vconv_update(vconv_update), .vconv_upd_input(vconv_upd_input),
		.iconv_update(iconv_update), .cal_active(cal_active),
		.power_update(power_update), .power_use_gpio(power_use_gpio),
		.status_new(status_new), .snap_alert(snap_alert));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// pulses stand one cycle, so one look per falling edge sees each once
	always @(negedge clk) begin
		// a write during calibration stretches it, so count the ends
		if (cal_d === 1'b1 && cal_active === 1'b0) nc++;
		cal_d = cal_active;
		if (converters_on === 1'b1 && cal_active === 1'b0) begin
			imask[vconv_input] = 1'b1;
		end
		if (vconv_update === 1'b1) begin
			nv++;
			vmask[vconv_upd_input] = 1'b1;
		end
		if (iconv_update === 2'h3) ni++;
		if (power_update === 2'h3) np++;
		if (power_update === 2'h3 && power_use_gpio === 1'b1) ng++;
		if (status_new === 2'h3) ns++;
		if (snap_alert === 1'b1) na++;
	end
	task automatic give_verdict();
		$display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// clear on the rising edge, away from the monitor's edge
	task automatic run(input logic [7:0] v, input int n);
		pmas_host_model_i.write_ctrl(v);
		@(posedge clk);
		{nv, ni, np, ns, na, nc, ng} = '0;
		{vmask, imask} = 16'h0;
		repeat (n) @(negedge clk);
	endtask : run
	task automatic wait_off();
		// skip the write's own edge, where the level is still settling
		@(negedge clk);
		for (k = 0; k < 400 && converters_on !== 1'b0; k++) @(negedge clk);
		if (k == 400) begin
			error_cnt++;
			$display("unexpected at %0t: converters never halt", $time);
			give_verdict();
		end
		repeat (60) @(negedge clk);
	endtask : wait_off
	initial begin
		rst_n = 1'b0;
		al_en = 2'h0;
		{nv, ni, np, ns, na, nc, ng, error_cnt, cmp_count} = '0;
		{vmask, imask} = 16'h0;
		repeat (6) @(negedge clk);
		chk(adc_sequence_control, pmas_pkg::CTRL_RESET);
		rst_n = 1'b1;
		repeat (300) @(negedge clk);
		chk(vmask, 8'h3f);
		chk(imask, 8'h3f);
		chk(8'(nc >= 2), 8'h01);
		$display("test defaults done");
		for (s = 0; s < 4; s++) begin
			run(8'h80 | 8'(s << 3), 400);
			chk(vmask, cmask[s]);
			chk(imask, cmask[s]);
			chk(8'(nc), 8'h01);
			chk(8'(ng > 0), 8'(s >= 2));
		end
		$display("test continuous done");
		for (s = 0; s < 8; s++) begin
			al_en = 2'(s);
			d = 8'h20 | 8'(s);
			run(d, 0);
			chk(adc_sequence_control, d);
			wait_off();
			emask = s < 6 ? 8'h01 << s : (s == 6 ? 8'h03 : 8'h0c);
			chk(vmask, emask);
			chk(imask, emask);
			chk(8'(nv), s < 6 ? 8'h01 : 8'h02);
			chk(8'(np), 8'(s >= 6));
			chk(8'(ng), 8'(s == 7));
			chk(8'(ni), 8'h01);
			chk(8'(ns), 8'h01);
			chk(8'(na), 8'(s % 4 != 0));
		end
		$display("test snapshot done");
		run(8'h40, 0);
		wait_off();
		chk(vmask, 8'h3f);
		chk(imask, 8'h3f);
		chk(8'(nv), 8'h06);
		chk(8'(ni), 8'h01);
		chk(8'(np), 8'h01);
		chk(8'(ng), 8'h00);
		$display("test single cycle done");
		run(8'h60, 300);
		chk(8'(converters_on), 8'h00);
		chk(8'(nv + ni), 8'h00);
		chk(imask, 8'h00);
		chk(adc_sequence_control, 8'h60);
		$display("test shutdown done");
		pmas_host_model_i.set_busy(1'b1);
		run(8'h20, 0);
		wait_off();
		chk(8'(nv + ni), 8'h00);
		chk(8'(np), 8'h00);
		pmas_host_model_i.set_busy(1'b0);
		run(8'h20, 0);
		wait_off();
		chk(8'(nv), 8'h01);
		$display("test bus blocking done");
		give_verdict();
	end
endmodule : test_power_monitor_adc_sequencer
`default_nettype wire
